// File: common/ssdl_map.vh
// Constants for the system-management space decode and lock block.
// Assumes a simple configuration write/read port and one host cycle per clock.
`ifndef SSDL_MAP_VH
`define SSDL_MAP_VH
`define SSDL_BIT_VIOLATION 0
`define SSDL_BIT_LOCK 1
`define SSDL_LOW_LSB 2
`define SSDL_LOW_MSB 3
`define SSDL_UP_LSB 4
`define SSDL_UP_MSB 5
`define SSDL_GMS_LSB 6
`define SSDL_GMS_MSB 7
`define SSDL_CTRL_RESET 8'h00
`define SSDL_SEL_OFF 2'h0
`define SSDL_SEL_01 2'h1
`define SSDL_SEL_10 2'h2
`define SSDL_SEL_11 2'h3
`define SSDL_AB_BASE 32'h000a0000
`define SSDL_AB_LAST 32'h000bffff
`define SSDL_HIGH_BASE 32'hfeea0000
`define SSDL_HIGH_LAST 32'hfeebffff
`define SSDL_TOP_512K 32'h00080000
`define SSDL_TOP_1M 32'h00100000
`define SSDL_ROUTE_DRAM 2'h0
`define SSDL_ROUTE_HUB 2'h1
`define SSDL_ROUTE_GFX 2'h2
`endif

// File: core/ssdl_space_decode_lock.v
// System-management space control register, AB/extended region decode and routing.
// Assumes a same-clock configuration port and a same-clock host cycle decode port.
`timescale 1ns/1ps
`default_nettype none
`include "ssdl_map.vh"

// Functional notes
// - Non-SMM hits on enabled top/high regions go to the hub, not DRAM.
// - Upper select field is read-only once the lock is set.
// - High region is enabled only when lower select equals 00.
// - Lower select 00 leaves AB segment DRAM disabled for everyone.
// - Lower select 01 maps AB segment to DRAM for any agent.
// - Lower select 10 lets only SMM code reads reach AB DRAM.
// - Lower select 11 gives all SMM cycles AB DRAM; others go elsewhere.
// - Under lock, lower bit 3 is read-only; bit 2 writable only if bit 3 is 1.
// - Lock freezes itself, graphics select, upper select and lower select MSB.
// - Lock is set by normal write and cleared only by reset.
// - Lock also blocks writes to both DRAM row population registers.
// - Non-SMM processor access to enabled extended region sets violation flag.
// - Explicit write-back cycles never set the violation flag.
// - Writing 1 clears the violation flag unless a new violation hits in that cycle; writing 0 leaves it.
// - Upper select decodes top region off/off/512 KB/1 MB, high conditional.
// - Top region sits below top of memory; high region at the fixed remap window.
module ssdl_space_decode_lock (
   // Clock and reset
   input wire i_clk,
   input wire i_srst,
   // Configuration access to the control register
   input wire i_cfg_wr,
   input wire [7:0] i_cfg_wdata,
   output wire [7:0] o_cfg_rdata,
   // Row population register write requests
   input wire i_drp_wr,
   input wire i_dram_row_population_second_wr,
   output wire o_drp_wr_allow,
   output wire o_dram_row_population_second_wr_allow,
   // Memory map inputs
   input wire [31:0] i_top_of_memory,
   // Host cycle to decode
   input wire i_cyc_valid,
   input wire [31:0] i_cyc_addr,
   input wire i_cyc_smm,
   input wire i_cyc_from_cpu,
   input wire i_cyc_code,
   input wire i_cyc_write,
   input wire i_cyc_writeback,
   input wire i_gfx_enabled,
   // Route result
   output reg [1:0] o_route,
   output reg o_route_valid,
   // Decoded state
   output wire o_smm_space_lock,
   output wire o_high_remap_enable,
   output wire o_top_stolen_enable
);
   reg smm_space_lock;
   reg extended_region_violation_flag;
   reg low_sel_msb;
   reg low_sel_lsb;
   wire [1:0] lower_segment_select;
   reg [1:0] upper_segment_select;
   reg [1:0] graphics_memory_select;
   reg next_low_lsb;
   reg [1:0] next_route;
   wire [31:0] top_size;
   wire [31:0] top_base;
   wire hit_ab;
   wire hit_high;
   wire hit_top;
   wire top_above_base;
   wire top_below_tom;
   wire ext_hit;
   wire viol_event;
   wire viol_clear;
   wire [1:0] ab_alt_route;

   assign lower_segment_select = {low_sel_msb, low_sel_lsb};

   assign o_cfg_rdata = {graphics_memory_select, upper_segment_select,
                         lower_segment_select, smm_space_lock,
                         extended_region_violation_flag};
   assign o_smm_space_lock = smm_space_lock;
   // Row population writes are refused quietly; the requester sees only the allow.
   assign o_drp_wr_allow = i_drp_wr & ~smm_space_lock;
   assign o_dram_row_population_second_wr_allow = i_dram_row_population_second_wr & ~smm_space_lock;

   // Top region size from upper select; 00 and 01 leave it off.
   assign top_size = (upper_segment_select == `SSDL_SEL_11) ? `SSDL_TOP_1M :
                     (upper_segment_select == `SSDL_SEL_10) ? `SSDL_TOP_512K :
                     32'h00000000;
   // A top of memory below the region size would wrap; software must not set that up.
   assign top_base = i_top_of_memory - top_size;
   assign o_top_stolen_enable = upper_segment_select[1];
   assign o_high_remap_enable = (upper_segment_select != `SSDL_SEL_OFF) &&
                                (lower_segment_select == `SSDL_SEL_OFF);
   // The AB segment window is fixed; only its owner changes.
   assign hit_ab = (i_cyc_addr >= `SSDL_AB_BASE) && (i_cyc_addr <= `SSDL_AB_LAST);
   assign hit_high = o_high_remap_enable && (i_cyc_addr >= `SSDL_HIGH_BASE) &&
                     (i_cyc_addr <= `SSDL_HIGH_LAST);
   assign top_above_base = (i_cyc_addr >= top_base);
   assign top_below_tom = (i_cyc_addr < i_top_of_memory);
   assign hit_top = o_top_stolen_enable && top_above_base && top_below_tom;
   assign ext_hit = hit_high | hit_top;

   // A host cycle that offends the extended regions; write-backs are exempt.
   assign viol_event = i_cyc_valid && i_cyc_from_cpu && !i_cyc_smm && !i_cyc_writeback &&
                       ext_hit;
   assign viol_clear = i_cfg_wr && i_cfg_wdata[`SSDL_BIT_VIOLATION];

   // AB cycles refused DRAM go to internal graphics when it is on, else to the hub.
   assign ab_alt_route = i_gfx_enabled ? `SSDL_ROUTE_GFX : `SSDL_ROUTE_HUB;

   // Bit 2 under lock only follows the write while bit 3 already reads 1.
   always @* begin
      next_low_lsb = lower_segment_select[0];
      if (!smm_space_lock || lower_segment_select[1]) begin
         next_low_lsb = i_cfg_wdata[`SSDL_LOW_LSB];
      end
   end

   // Only a write can set the lock, and nothing but reset clears it.
   always @(posedge i_clk) begin
      if (i_srst) begin
         smm_space_lock <= 1'b0;
      end else if (i_cfg_wr && !smm_space_lock) begin
         smm_space_lock <= i_cfg_wdata[`SSDL_BIT_LOCK];
      end
   end

   // Graphics select freezes with the lock.
   always @(posedge i_clk) begin
      if (i_srst) begin
         graphics_memory_select <= 2'h0;
      end else if (i_cfg_wr && !smm_space_lock) begin
         graphics_memory_select <= i_cfg_wdata[`SSDL_GMS_MSB:`SSDL_GMS_LSB];
      end
   end

   // Upper select freezes with the lock so the extended regions cannot be reopened.
   always @(posedge i_clk) begin
      if (i_srst) begin
         upper_segment_select <= 2'h0;
      end else if (i_cfg_wr && !smm_space_lock) begin
         upper_segment_select <= i_cfg_wdata[`SSDL_UP_MSB:`SSDL_UP_LSB];
      end
   end

   // Lower select MSB freezes with the lock.
   always @(posedge i_clk) begin
      if (i_srst) begin
         low_sel_msb <= 1'b0;
      end else if (i_cfg_wr && !smm_space_lock) begin
         low_sel_msb <= i_cfg_wdata[`SSDL_LOW_MSB];
      end
   end

   // Bit 2 may still move under lock while bit 3 reads 1, toggling code-only shadowing.
   always @(posedge i_clk) begin
      if (i_srst) begin
         low_sel_lsb <= 1'b0;
      end else if (i_cfg_wr) begin
         low_sel_lsb <= next_low_lsb;
      end
   end

   // A new violation in the same cycle as a clearing write keeps the flag set.
   always @(posedge i_clk) begin
      if (i_srst) begin
         extended_region_violation_flag <= 1'b0;
      end else if (viol_event) begin
         extended_region_violation_flag <= 1'b1;
      end else if (viol_clear) begin
         extended_region_violation_flag <= 1'b0;
      end
   end

   // Non-DRAM target for the AB segment depends on whether graphics owns it.
   always @* begin
      next_route = `SSDL_ROUTE_DRAM;
      if (ext_hit) begin
         next_route = i_cyc_smm ? `SSDL_ROUTE_DRAM : `SSDL_ROUTE_HUB;
      end else if (hit_ab) begin
         case (lower_segment_select)
            `SSDL_SEL_OFF: next_route = `SSDL_ROUTE_HUB;
            `SSDL_SEL_01: next_route = `SSDL_ROUTE_DRAM;
            `SSDL_SEL_10: begin
               if (i_cyc_smm && i_cyc_from_cpu && i_cyc_code && !i_cyc_write) begin
                  next_route = `SSDL_ROUTE_DRAM;
               end else begin
                  next_route = `SSDL_ROUTE_HUB;
               end
            end
            `SSDL_SEL_11: next_route = i_cyc_smm ? `SSDL_ROUTE_DRAM : `SSDL_ROUTE_HUB;
            default: next_route = `SSDL_ROUTE_HUB;
         endcase
         if (next_route == `SSDL_ROUTE_HUB) begin
            next_route = ab_alt_route;
         end
      end
   end

   // Route result is registered and appears one clock after the cycle that produced it.
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_route <= `SSDL_ROUTE_DRAM;
      end else begin
         o_route <= next_route;
      end
   end

   always @(posedge i_clk) begin
      if (i_srst) begin
         o_route_valid <= 1'b0;
      end else begin
         o_route_valid <= i_cyc_valid;
      end
   end
endmodule
`default_nettype wire

// File: tb/ssdl_monitor.sv
// Checker for the SMM space decode and lock block.
// Bound to the design top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ssdl_monitor (
   // Clock, reset and configuration
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_cfg_wr,
   input wire logic [7:0] i_cfg_wdata,
   input wire logic [7:0] o_cfg_rdata,
   // Host cycle and results
   input wire logic i_cyc_valid,
   input wire logic [31:0] i_cyc_addr,
   input wire logic i_cyc_smm,
   input wire logic i_cyc_from_cpu,
   input wire logic i_cyc_writeback,
   input wire logic [1:0] o_route,
   input wire logic o_smm_space_lock,
   input wire logic o_high_remap_enable
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   wire hv = i_cyc_valid && !i_cyc_smm && o_high_remap_enable && i_cyc_addr[31:17] == 15'h7f75;
   AST_LK_HOLD: assert property (!i_srst && o_smm_space_lock |=> o_smm_space_lock) else $error("lock");
   AST_LK_SET: assert property (i_cfg_wr && i_cfg_wdata[1] |=> o_smm_space_lock) else $error("set");
   AST_FROZEN: assert property (!i_srst && o_smm_space_lock |=> $stable(o_cfg_rdata[7:3])) else $error("ro");
   AST_LOW_LSB: assert property (!i_srst && o_smm_space_lock && !o_cfg_rdata[3] |=> $stable(o_cfg_rdata[2]))
      else $error("lsb");
   AST_HIGH: assert property (o_high_remap_enable |-> o_cfg_rdata[3:2] == 2'h0 && o_cfg_rdata[5:4] != 2'h0)
      else $error("high");
   AST_HUB: assert property (hv |=> o_route == 2'h1) else $error("hub");
   AST_VIOL: assert property (hv && i_cyc_from_cpu && !i_cyc_writeback |=> o_cfg_rdata[0]) else $error("viol");
   AST_W1C: assert property (i_cfg_wr && i_cfg_wdata[0] && !i_cyc_valid |=> !o_cfg_rdata[0]) else $error("w1c");
   cover property (hv);
   cover property (o_smm_space_lock && i_cfg_wr);
   cover property (i_cfg_wr && i_cfg_wdata[0]);
endmodule
`default_nettype wire

// File: tb/ssdl_host_model.sv
// Host processor model: issues one decoded cycle per call.
// Assumes the bench clock; drives just after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module ssdl_host_model (
   // Clock and cycle bundle {gfx, valid, cpu, smm, code, write, wb, addr}
   input wire logic i_clk,
   output var logic [38:0] o_cyc
);
   initial o_cyc = 39'h0;
   task automatic cyc(input logic [5:0] q, input logic [31:0] a);
      @(posedge i_clk);
      o_cyc <= {q[5], 1'b1, q[4:0], a};
      @(posedge i_clk);
      // A released address is flipped so a stale value never looks live.
      o_cyc <= {q[5], 1'b0, q[4:0], ~a};
   endtask
endmodule
`default_nettype wire

// File: tb/test_smm_space_decode_lock.sv
// Bench for the SMM space decode and lock block with a host cycle model.
// Assumes a free-running 25 MHz clock and the checker bound below.
`timescale 1ns/1ps
`default_nettype none
module test_smm_space_decode_lock;
   logic clk = 0, rst = 1, wr = 0;
   logic [7:0] wd = 8'h00;
   wire [7:0] rd;
   wire [38:0] c;
   wire [1:0] rt;
   wire al, al2, rv, te, hr, lk;
   int err_total = 0, checks_done = 0, cyc_n = 0;
   always #20 clk = ~clk;
   ssdl_host_model host_u (.i_clk(clk), .o_cyc(c));
   ssdl_space_decode_lock dut_u (.i_clk(clk), .i_srst(rst), .i_cfg_wr(wr), .i_cfg_wdata(wd),
      .o_cfg_rdata(rd), .i_drp_wr(1'b1), .i_dram_row_population_second_wr(1'b1), .o_drp_wr_allow(al),
      .o_dram_row_population_second_wr_allow(al2), .i_top_of_memory(32'h04000000), .i_cyc_valid(c[37]),
      .i_cyc_addr(c[31:0]), .i_cyc_smm(c[35]), .i_cyc_from_cpu(c[36]), .i_cyc_code(c[34]),
      .i_cyc_write(c[33]), .i_cyc_writeback(c[32]), .i_gfx_enabled(c[38]), .o_route(rt),
      .o_route_valid(rv), .o_smm_space_lock(lk), .o_high_remap_enable(hr),
      .o_top_stolen_enable(te));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic put(input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic go(input logic [5:0] q, input logic [31:0] a, input logic [1:0] e);
      host_u.cyc(q, a);
      #1;
      chk({6'h0, rt}, {6'h0, e});
      chk({7'h0, rv}, 8'h01);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         err_total++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(rd, 8'h00);
      for (int s = 0; s < 4; s++) begin
         put(8'(s << 2));
         go(6'h10, 32'h000a0000, (s == 1) ? 2'h0 : 2'h1);
         go(6'h1c, 32'h000b0000, (s == 0) ? 2'h1 : 2'h0);
         go(6'h1a, 32'h000bfff0, s[0] ? 2'h0 : 2'h1);
      end
      put(8'h00);
      go(6'h30, 32'h000a0000, 2'h2);
      put(8'h10);
      go(6'h10, 32'hfeea0000, 2'h1);
      chk(rd, 8'h11);
      put(8'h10);
      chk(rd, 8'h11);
      put(8'h11);
      chk(rd, 8'h10);
      go(6'h11, 32'hfeebfff0, 2'h1);
      chk(rd, 8'h10);
      go(6'h18, 32'hfeea0000, 2'h0);
      put(8'h20);
      chk({7'h0, te}, 8'h01);
      go(6'h10, 32'h03f7fff0, 2'h0);
      go(6'h10, 32'h03f80000, 2'h1);
      chk(rd, 8'h21);
      put(8'h31);
      go(6'h10, 32'h03f7fff0, 2'h1);
      go(6'h18, 32'h03ffff00, 2'h0);
      put(8'h31);
      chk(rd, 8'h30);
      put(8'h14);
      go(6'h10, 32'hfeea0000, 2'h0);
      chk({7'h0, hr}, 8'h00);
      chk(rd, 8'h14);
      chk({6'h0, al, al2}, 8'h03);
      put(8'h16);
      put(8'hec);
      chk(rd, 8'h16);
      chk({6'h0, al, al2}, 8'h00);
      chk({7'h0, lk}, 8'h01);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(rd, 8'h00);
      put(8'h0e);
      put(8'h08);
      chk(rd, 8'h0a);
      tally_and_finish;
   end
endmodule
bind ssdl_space_decode_lock ssdl_monitor mon_u (.i_clk(i_clk), .i_srst(i_srst),
   .i_cfg_wr(i_cfg_wr), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
   .i_cyc_valid(i_cyc_valid), .i_cyc_addr(i_cyc_addr), .i_cyc_smm(i_cyc_smm),
   .i_cyc_from_cpu(i_cyc_from_cpu), .i_cyc_writeback(i_cyc_writeback), .o_route(o_route),
   .o_smm_space_lock(o_smm_space_lock), .o_high_remap_enable(o_high_remap_enable));
`default_nettype wire
